// ==== rtl/network_fault_reaction_ctrl.sv ====
// reaction of the drive to a fieldbus link error, with AXI4-Lite registers and one interrupt
// assumes link_error and motor_stopped come from logic on aclk; one write and one read at a time
//
// Notes on behaviour
// - reaction chosen by fault_reaction_select; timed reactions use fault_reaction_delay.
// - fault-mode attribute 0x29/0x01/0x10 is writable by the network master.
// - selector and attribute interlocked; writing either updates the other when the value has a mapping.
// - codes 0 and 4..9 coast at once and trip.
// - code 1 waits the delay (0.0..60.0 s) then coasts and trips.
// - code 2 ignores errors recovered within delay, else coasts and trips.
// - code 3 keeps running, no trip.
// - code 10 decelerates at once, trips only once stopped.
// - code 11 waits the delay, decelerates, trips only once stopped.
// - code 12 ignores recovered errors, else decelerates on expiry and trips only once stopped.
// - every decelerate-stop uses the decel_time_param ramp.
// - code 13 clears the run command at once, no trip.
// - code 14 forces forward rotation, only while network_control_flag is 1.
// - code 15 forces reverse rotation, only while network_control_flag is 1.
// - attribute 0,1,2,3,4 maps to selector 13,3,12,14,15.
// - attribute 100,101,102,110,111,112 maps to 0,1,2,10,11,12.
// - a trip records alarm code 35 as the current alarm code.
`timescale 1ns/1ns
module network_fault_reaction_ctrl
  import nfr_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // network interface
  input  wire logic        link_error,
  input  wire logic        net_wr_valid,
  input  wire logic [7:0]  net_class,
  input  wire logic [7:0]  net_inst,
  input  wire logic [7:0]  net_attr_id,
  input  wire logic [7:0]  net_wr_data,
  output logic             net_wr_done,
  output logic [7:0]       net_fault_mode_attr,
  // drive run/stop control
  input  wire logic        motor_stopped,
  output logic             coast_stop,
  output logic             decel_stop,
  output logic [15:0]      decel_ramp_time,
  output logic             run_cmd_off,
  output logic             force_fwd,
  output logic             force_rev,
  output logic             network_comm_trip,
  output logic [7:0]       current_alarm_code,
  // interrupt
  output logic             irq
);

  logic [7:0]            select_r;
  logic [7:0]            attr_r;
  logic [9:0]            delay_r;
  logic [15:0]           decel_r;
  logic                  network_control_flag_r;
  logic [IRQ_W-1:0]      irq_stat_r;
  logic [IRQ_W-1:0]      irq_en_r;
  logic [IRQ_W-1:0]      irq_ev;
  logic [IRQ_W-1:0]      irq_clr;
  logic                  bvalid_r;
  logic [1:0]            bresp_r;
  logic                  rvalid_r;
  logic [1:0]            rresp_r;
  logic [31:0]           rdata_r;
  logic                  wr_fire;
  logic                  rd_fire;
  logic                  wr_ok;
  logic                  rd_ok;
  logic [31:0]           rd_data;
  logic [15:0]           wr_lo;
  logic [9:0]            wr_delay;
  logic                  trip_rst;
  logic                  net_hit;
  logic [TICK_CNT_W-1:0] tick_cnt_r;
  logic                  tick;
  logic [9:0]            timer_r;
  logic                  expired;
  logic                  link_q_r;
  state_t                state_r;
  state_t                state_nxt;
  act_t                  act_r;
  act_t                  act_nxt;
  act_t                  cur_act;
  logic [7:0]            alarm_r;

  function automatic act_t sel_to_act(input logic [7:0] s);
    case (s)
      SEL_DLY_COAST:   return ACT_DLY_COAST;
      SEL_GRACE_COAST: return ACT_GRACE_COAST;
      SEL_IGNORE:      return ACT_IGNORE;
      SEL_DECEL:       return ACT_DECEL;
      SEL_DLY_DECEL:   return ACT_DLY_DECEL;
      SEL_GRACE_DECEL: return ACT_GRACE_DECEL;
      SEL_RUN_OFF:     return ACT_RUN_OFF;
      SEL_FWD:         return ACT_FWD;
      SEL_REV:         return ACT_REV;
      default:         return ACT_COAST;
    endcase
  endfunction

  // bit 8 flags a defined attribute value
  function automatic logic [8:0] attr_to_sel(input logic [7:0] a);
    case (a)
      ATTR_RUN_OFF:     return {1'b1, SEL_RUN_OFF};
      ATTR_IGNORE:      return {1'b1, SEL_IGNORE};
      ATTR_GRACE_DECEL: return {1'b1, SEL_GRACE_DECEL};
      ATTR_FWD:         return {1'b1, SEL_FWD};
      ATTR_REV:         return {1'b1, SEL_REV};
      ATTR_COAST:       return {1'b1, SEL_COAST};
      ATTR_DLY_COAST:   return {1'b1, SEL_DLY_COAST};
      ATTR_GRACE_COAST: return {1'b1, SEL_GRACE_COAST};
      ATTR_DECEL:       return {1'b1, SEL_DECEL};
      ATTR_DLY_DECEL:   return {1'b1, SEL_DLY_DECEL};
      ATTR_GRACE_ALT:   return {1'b1, SEL_GRACE_DECEL};
      default:          return {1'b0, SEL_COAST};
    endcase
  endfunction

  // selector 12 reads back as attribute 2; codes 4..9 have no attribute
  function automatic logic [8:0] sel_to_attr(input logic [7:0] s);
    case (s)
      SEL_RUN_OFF:     return {1'b1, ATTR_RUN_OFF};
      SEL_IGNORE:      return {1'b1, ATTR_IGNORE};
      SEL_GRACE_DECEL: return {1'b1, ATTR_GRACE_DECEL};
      SEL_FWD:         return {1'b1, ATTR_FWD};
      SEL_REV:         return {1'b1, ATTR_REV};
      SEL_COAST:       return {1'b1, ATTR_COAST};
      SEL_DLY_COAST:   return {1'b1, ATTR_DLY_COAST};
      SEL_GRACE_COAST: return {1'b1, ATTR_GRACE_COAST};
      SEL_DECEL:       return {1'b1, ATTR_DECEL};
      SEL_DLY_DECEL:   return {1'b1, ATTR_DLY_DECEL};
      default:         return {1'b0, ATTR_COAST};
    endcase
  endfunction

  // write address and data are taken together, one write in flight
  assign wr_fire       = s_axi_awvalid & s_axi_wvalid & ~bvalid_r;
  assign s_axi_awready = wr_fire;
  assign s_axi_wready  = wr_fire;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign rd_fire       = s_axi_arvalid & ~rvalid_r;
  assign s_axi_arready = ~rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rresp   = rresp_r;
  assign s_axi_rdata   = rdata_r;

  assign wr_lo[7:0]  = s_axi_wstrb[0] ? s_axi_wdata[7:0] : decel_r[7:0];
  assign wr_lo[15:8] = s_axi_wstrb[1] ? s_axi_wdata[15:8] : decel_r[15:8];
  // delay lanes merged separately; values beyond 60.0 s are clamped
  always_comb begin
    wr_delay = delay_r;
    if (s_axi_wstrb[0]) begin
      wr_delay[7:0] = s_axi_wdata[7:0];
    end
    if (s_axi_wstrb[1]) begin
      wr_delay[9:8] = s_axi_wdata[9:8];
    end
    if (wr_delay > DELAY_MAX) begin
      wr_delay = DELAY_MAX;
    end
  end

  always_comb begin
    case (s_axi_awaddr)
      OFS_SELECT, OFS_DELAY, OFS_DECEL, OFS_ATTR, OFS_CTRL,
      OFS_STATUS, OFS_ALARM, OFS_IRQ_STAT, OFS_IRQ_CLR, OFS_IRQ_EN: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  always_comb begin
    rd_data = 32'h0;
    rd_ok   = 1'b1;
    case (s_axi_araddr)
      OFS_SELECT:   rd_data = {24'h0, select_r};
      OFS_DELAY:    rd_data = {22'h0, delay_r};
      OFS_DECEL:    rd_data = {16'h0, decel_r};
      OFS_ATTR:     rd_data = {24'h0, attr_r};
      OFS_CTRL:     rd_data = {30'h0, network_control_flag_r, 1'b0};
      OFS_STATUS:   rd_data = {20'h0, act_r, 2'h0, motor_stopped, network_comm_trip, link_error, state_r};
      OFS_ALARM:    rd_data = {24'h0, alarm_r};
      OFS_IRQ_STAT: rd_data = {29'h0, irq_stat_r};
      OFS_IRQ_CLR:  rd_data = 32'h0;
      OFS_IRQ_EN:   rd_data = {29'h0, irq_en_r};
      default:      rd_ok   = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rresp_r  <= RESP_OKAY;
      rdata_r  <= 32'h0;
    end else if (rd_fire) begin
      rvalid_r <= 1'b1;
      rresp_r  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      rdata_r  <= rd_data;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  logic       wr_sel;
  logic       wr_attr;
  logic [8:0] net_map;
  logic [8:0] bus_map;
  logic [8:0] sel_map;
  // a function result cannot be part-selected, so the mappings are held as nets
  assign net_map = attr_to_sel(net_wr_data);
  assign bus_map = attr_to_sel(s_axi_wdata[7:0]);
  assign sel_map = sel_to_attr(s_axi_wdata[7:0]);
  assign wr_sel  = wr_fire & (s_axi_awaddr == OFS_SELECT) & s_axi_wstrb[0];
  assign wr_attr = wr_fire & (s_axi_awaddr == OFS_ATTR) & s_axi_wstrb[0];
  assign net_hit = net_wr_valid & (net_class == NET_CLASS) & (net_inst == NET_INST)
                 & (net_attr_id == NET_ATTR_ID);

  // a network write wins over a bus write in the same cycle; the bus write to selector or attribute is dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      select_r <= SELECT_RST;
      attr_r   <= ATTR_RST;
    end else if (net_hit) begin
      attr_r <= net_wr_data;
      if (net_map[8]) begin
        select_r <= net_map[7:0];
      end
    end else if (wr_attr) begin
      attr_r <= s_axi_wdata[7:0];
      if (bus_map[8]) begin
        select_r <= bus_map[7:0];
      end
    end else if (wr_sel) begin
      select_r <= s_axi_wdata[7:0];
      if (sel_map[8]) begin
        attr_r <= sel_map[7:0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      net_wr_done <= 1'b0;
    end else begin
      net_wr_done <= net_hit;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      delay_r   <= DELAY_RST;
      decel_r   <= DECEL_RST;
      network_control_flag_r <= 1'b0;
      irq_en_r  <= '0;
    end else if (wr_fire) begin
      if (s_axi_awaddr == OFS_DELAY) begin
        delay_r <= wr_delay;
      end
      if (s_axi_awaddr == OFS_DECEL) begin
        decel_r <= wr_lo;
      end
      if (s_axi_awaddr == OFS_CTRL && s_axi_wstrb[0]) begin
        network_control_flag_r <= s_axi_wdata[CTRL_NETWORK_CONTROL_FLAG];
      end
      if (s_axi_awaddr == OFS_IRQ_EN && s_axi_wstrb[0]) begin
        irq_en_r <= s_axi_wdata[IRQ_W-1:0];
      end
    end
  end

  assign trip_rst = wr_fire & s_axi_wstrb[0] & (s_axi_awaddr == OFS_CTRL) & s_axi_wdata[CTRL_TRIP_RST];

  // free-running 0.1 s time base; a wait may run up to one tick short
  assign tick = (tick_cnt_r == TICK_CNT_W'(TICK_LEN - 1));
  always_ff @(posedge aclk) begin
    if (!aresetn || tick) begin
      tick_cnt_r <= '0;
    end else begin
      tick_cnt_r <= tick_cnt_r + 1'b1;
    end
  end

  assign expired = (timer_r >= delay_r);
  always_ff @(posedge aclk) begin
    if (!aresetn || !link_error || (state_r != ST_WAIT && state_r != ST_GRACE)) begin
      timer_r <= '0;
    end else if (tick && !expired) begin
      timer_r <= timer_r + 1'b1;
    end
  end

  assign cur_act = sel_to_act(select_r);
  always_comb begin
    state_nxt = state_r;
    act_nxt   = act_r;
    case (state_r)
      ST_IDLE: begin
        if (link_error && cur_act != ACT_IGNORE) begin
          act_nxt = cur_act;
          case (cur_act)
            ACT_COAST:                      state_nxt = ST_TRIP;
            ACT_DLY_COAST, ACT_DLY_DECEL:   state_nxt = ST_WAIT;
            ACT_GRACE_COAST, ACT_GRACE_DECEL: state_nxt = ST_GRACE;
            ACT_DECEL:                      state_nxt = ST_DECEL;
            default:                        state_nxt = ST_HOLD;
          endcase
        end
      end
      ST_WAIT: begin
        if (expired) begin
          state_nxt = (act_r == ACT_DLY_COAST) ? ST_TRIP : ST_DECEL;
        end
      end
      ST_GRACE: begin
        if (!link_error) begin
          state_nxt = ST_IDLE;
        end else if (expired) begin
          state_nxt = (act_r == ACT_GRACE_COAST) ? ST_TRIP : ST_DECEL;
        end
      end
      ST_DECEL: begin
        if (motor_stopped) begin
          state_nxt = ST_TRIP;
        end
      end
      ST_TRIP: begin
        if (trip_rst && !link_error) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_HOLD: begin
        if (!link_error) begin
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r           <= ST_IDLE;
      act_r             <= ACT_COAST;
      coast_stop        <= 1'b0;
      decel_stop        <= 1'b0;
      run_cmd_off       <= 1'b0;
      force_fwd         <= 1'b0;
      force_rev         <= 1'b0;
      network_comm_trip <= 1'b0;
    end else begin
      state_r           <= state_nxt;
      act_r             <= act_nxt;
      coast_stop        <= (state_nxt == ST_TRIP);
      decel_stop        <= (state_nxt == ST_DECEL);
      run_cmd_off       <= (state_nxt == ST_HOLD) && (act_nxt == ACT_RUN_OFF);
      force_fwd         <= (state_nxt == ST_HOLD) && (act_nxt == ACT_FWD) && network_control_flag_r;
      force_rev         <= (state_nxt == ST_HOLD) && (act_nxt == ACT_REV) && network_control_flag_r;
      network_comm_trip <= (state_nxt == ST_TRIP);
    end
  end
  assign decel_ramp_time     = decel_r;
  assign net_fault_mode_attr = attr_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      alarm_r <= ALARM_NONE;
    end else if (state_nxt == ST_TRIP) begin
      alarm_r <= ALARM_NET_COMM;
    end else if (state_r == ST_TRIP) begin
      alarm_r <= ALARM_NONE;
    end
  end
  assign current_alarm_code = alarm_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link_q_r <= 1'b0;
    end else begin
      link_q_r <= link_error;
    end
  end

  // events win over a clear in the same cycle
  assign irq_ev[IRQ_ERR]  = link_error & ~link_q_r;
  assign irq_ev[IRQ_TRIP] = (state_nxt == ST_TRIP) & (state_r != ST_TRIP);
  assign irq_ev[IRQ_REST] = ~link_error & link_q_r;
  assign irq_clr = (wr_fire && s_axi_awaddr == OFS_IRQ_CLR && s_axi_wstrb[0]) ? s_axi_wdata[IRQ_W-1:0] : '0;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_r <= '0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_ev;
    end
  end
  assign irq = |(irq_stat_r & irq_en_r);

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_err_in_idle;
    (state_r == ST_IDLE) && link_error;
  endsequence

  property p_coast_now;
    s_err_in_idle ##0 (cur_act == ACT_COAST) |=> network_comm_trip && coast_stop && alarm_r == ALARM_NET_COMM;
  endproperty
  a_coast_now: assert property (p_coast_now) else $error("immediate coast trip missing");

  property p_ignore;
    s_err_in_idle ##0 (cur_act == ACT_IGNORE) |=> !network_comm_trip && state_r == ST_IDLE;
  endproperty
  a_ignore: assert property (p_ignore) else $error("ignore mode reacted");

  property p_hold_no_trip;
    (state_r == ST_HOLD) |-> !network_comm_trip && !coast_stop;
  endproperty
  a_hold_no_trip: assert property (p_hold_no_trip) else $error("hold mode tripped");

  property p_decel_trip;
    (state_r == ST_DECEL) && !motor_stopped |=> !network_comm_trip;
  endproperty
  a_decel_trip: assert property (p_decel_trip) else $error("trip before motor stopped");

  property p_grace_cancel;
    (state_r == ST_GRACE) && !link_error |=> state_r == ST_IDLE && !network_comm_trip;
  endproperty
  a_grace_cancel: assert property (p_grace_cancel) else $error("grace not cancelled");

  property p_wait_early;
    (state_r == ST_WAIT) && (timer_r < delay_r) |=> state_r == ST_WAIT;
  endproperty
  a_wait_early: assert property (p_wait_early) else $error("delay left early");

  property p_force_fwd;
    force_fwd |-> network_control_flag_r || $past(network_control_flag_r);
  endproperty
  a_force_fwd: assert property (p_force_fwd) else $error("forward forced without control");

  property p_force_rev;
    force_rev |-> network_comm_trip == 1'b0 && (network_control_flag_r || $past(network_control_flag_r));
  endproperty
  a_force_rev: assert property (p_force_rev) else $error("reverse forced without control");

  property p_attr_zero;
    net_hit && net_wr_data == ATTR_RUN_OFF |=> select_r == SEL_RUN_OFF;
  endproperty
  a_attr_zero: assert property (p_attr_zero) else $error("attribute 0 not mapped");

  property p_attr_alt;
    net_hit && net_wr_data == ATTR_GRACE_ALT |=> select_r == SEL_GRACE_DECEL && attr_r == ATTR_GRACE_ALT;
  endproperty
  a_attr_alt: assert property (p_attr_alt) else $error("attribute 112 not mapped");

  property p_timer_clear;
    !link_error |=> timer_r == 10'h000;
  endproperty
  a_timer_clear: assert property (p_timer_clear) else $error("timer not cleared");

endmodule

// ==== rtl/nfr_pkg.sv ====
// constants, codes and register map of the network fault reaction controller
// assumes a 250 MHz bus clock and a 32-bit AXI4-Lite register bus
package nfr_pkg;
  localparam int CLK_PERIOD_NS  = 4;
  localparam int TICK_PERIOD_NS = 100_000_000;
  localparam int TICK_CYCLES    = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_CNT_W     = 25;
  localparam logic [9:0] DELAY_MAX = 10'h258;
  localparam logic [7:0] OFS_SELECT   = 8'h00;
  localparam logic [7:0] OFS_DELAY    = 8'h04;
  localparam logic [7:0] OFS_DECEL    = 8'h08;
  localparam logic [7:0] OFS_ATTR     = 8'h0c;
  localparam logic [7:0] OFS_CTRL     = 8'h10;
  localparam logic [7:0] OFS_STATUS   = 8'h14;
  localparam logic [7:0] OFS_ALARM    = 8'h18;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h1c;
  localparam logic [7:0] OFS_IRQ_CLR  = 8'h20;
  localparam logic [7:0] OFS_IRQ_EN   = 8'h24;
  localparam int CTRL_TRIP_RST = 0;
  localparam int CTRL_NETWORK_CONTROL_FLAG  = 1;
  localparam int IRQ_ERR  = 0;
  localparam int IRQ_TRIP = 1;
  localparam int IRQ_REST = 2;
  localparam int IRQ_W    = 3;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [7:0] NET_CLASS   = 8'h29;
  localparam logic [7:0] NET_INST    = 8'h01;
  localparam logic [7:0] NET_ATTR_ID = 8'h10;
  localparam logic [7:0] ALARM_NONE     = 8'h00;
  localparam logic [7:0] ALARM_NET_COMM = 8'h23;
  localparam logic [7:0] SEL_COAST       = 8'h00;
  localparam logic [7:0] SEL_DLY_COAST   = 8'h01;
  localparam logic [7:0] SEL_GRACE_COAST = 8'h02;
  localparam logic [7:0] SEL_IGNORE      = 8'h03;
  localparam logic [7:0] SEL_DECEL       = 8'h0a;
  localparam logic [7:0] SEL_DLY_DECEL   = 8'h0b;
  localparam logic [7:0] SEL_GRACE_DECEL = 8'h0c;
  localparam logic [7:0] SEL_RUN_OFF     = 8'h0d;
  localparam logic [7:0] SEL_FWD         = 8'h0e;
  localparam logic [7:0] SEL_REV         = 8'h0f;
  localparam logic [7:0] ATTR_RUN_OFF     = 8'h00;
  localparam logic [7:0] ATTR_IGNORE      = 8'h01;
  localparam logic [7:0] ATTR_GRACE_DECEL = 8'h02;
  localparam logic [7:0] ATTR_FWD         = 8'h03;
  localparam logic [7:0] ATTR_REV         = 8'h04;
  localparam logic [7:0] ATTR_COAST       = 8'h64;
  localparam logic [7:0] ATTR_DLY_COAST   = 8'h65;
  localparam logic [7:0] ATTR_GRACE_COAST = 8'h66;
  localparam logic [7:0] ATTR_DECEL       = 8'h6e;
  localparam logic [7:0] ATTR_DLY_DECEL   = 8'h6f;
  localparam logic [7:0] ATTR_GRACE_ALT   = 8'h70;
  localparam logic [7:0]  SELECT_RST = 8'h00;
  localparam logic [7:0]  ATTR_RST   = 8'h64;
  localparam logic [9:0]  DELAY_RST  = 10'h000;
  localparam logic [15:0] DECEL_RST  = 16'h0000;
  typedef enum logic [3:0] {
    ACT_COAST       = 4'h0,
    ACT_DLY_COAST   = 4'h1,
    ACT_GRACE_COAST = 4'h2,
    ACT_IGNORE      = 4'h3,
    ACT_DECEL       = 4'h4,
    ACT_DLY_DECEL   = 4'h5,
    ACT_GRACE_DECEL = 4'h6,
    ACT_RUN_OFF     = 4'h7,
    ACT_FWD         = 4'h8,
    ACT_REV         = 4'h9
  } act_t;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_WAIT  = 3'h1,
    ST_GRACE = 3'h2,
    ST_DECEL = 3'h3,
    ST_TRIP  = 3'h4,
    ST_HOLD  = 3'h5
  } state_t;
endpackage

// ==== sim/drive_model.sv ====
// drive model: the motor reaches standstill a few cycles after a decel request
// assumes decel_stop is a level on aclk
`timescale 1ns/1ns
module drive_model (
  input  wire logic aclk,
  input  wire logic decel_stop,
  output logic      motor_stopped
);
  logic [2:0] cnt_r;
  // a slow stop shows that the trip really waits for standstill
  always_ff @(posedge aclk) begin
    cnt_r <= decel_stop ? cnt_r + 3'h1 : 3'h0;
    motor_stopped <= &cnt_r;
  end
endmodule

// ==== sim/network_fault_reaction_ctrl_tb.sv ====
// bench for the network fault reaction controller
// assumes drive_model on the run/stop side and a 4-cycle tick
`timescale 1ns/1ns
module network_fault_reaction_ctrl_tb;
  import nfr_pkg::*;
  logic        aclk = 0;
  logic        aresetn = 0;
  localparam logic [23:0] NA = {NET_CLASS, NET_INST, NET_ATTR_ID};
  logic [7:0]  awa = 0, ara = 0, ncls = 0, ninst = 0, nattr = 0, nd = 0, attr, alarm;
  logic [31:0] wd = 0, rdata;
  logic        awv = 0, wv = 0, arv = 0, le = 0, nwv = 0;
  logic        awr, wry, bv, arr, rv, done, ms, cs, dst, roff, ff, fr, trip, irq;
  logic [1:0]  br, bresp, rresp;
  logic [15:0] ramp;
  int          n_mismatch = 0, num_checks = 0, cyc = 0;
  always #2 aclk = ~aclk;
  network_fault_reaction_ctrl #(.TICK_LEN(4)) dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wry),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(1'b1), .s_axi_araddr(ara),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv), .s_axi_rready(1'b1), .link_error(le), .net_wr_valid(nwv),
    .net_class(ncls), .net_inst(ninst), .net_attr_id(nattr), .net_wr_data(nd),
    .net_wr_done(done), .net_fault_mode_attr(attr), .motor_stopped(ms), .coast_stop(cs),
    .decel_stop(dst), .decel_ramp_time(ramp), .run_cmd_off(roff), .force_fwd(ff),
    .force_rev(fr), .network_comm_trip(trip), .current_alarm_code(alarm), .irq(irq));
  drive_model model (.aclk(aclk), .decel_stop(dst), .motor_stopped(ms));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("mismatch %0t seen %h want %h", $time, s, e);
    end
  endtask
  task automatic end_of_test();
    if (n_mismatch == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // bready and rready stay high, so every answer is taken at once
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awa <= a;
    wd <= d;
    awv <= 1;
    wv <= 1;
    @(posedge aclk);
    while (awr !== 1'b1) @(posedge aclk);
    awv <= 0;
    wv <= 0;
    @(posedge aclk);
    while (bv !== 1'b1) @(posedge aclk);
    br = bresp;
  endtask
  task automatic rdr(input logic [7:0] a, input logic [31:0] e);
    ara <= a;
    arv <= 1;
    @(posedge aclk);
    while (arr !== 1'b1) @(posedge aclk);
    arv <= 0;
    @(posedge aclk);
    while (rv !== 1'b1) @(posedge aclk);
    chk(rdata, e);
    chk(rresp, (a > OFS_IRQ_EN) ? RESP_SLVERR : RESP_OKAY);
  endtask
  task automatic nw(input logic [23:0] a, input logic [7:0] d);
    {ncls, ninst, nattr} <= a;
    nd <= d;
    nwv <= 1;
    @(posedge aclk);
    nwv <= 0;
    @(posedge aclk);
    chk(done, a == NA);
  endtask
  task automatic err(input logic [7:0] s, input int n);
    wr(OFS_SELECT, s);
    le <= 1;
    repeat (n) @(posedge aclk);
  endtask
  // a trip only resets with the link healthy again
  task automatic clr();
    le <= 0;
    wr(OFS_CTRL, 32'h1);
  endtask
  task automatic t_map();
    logic [7:0] av [11] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h64, 8'h65, 8'h66, 8'h6e, 8'h6f, 8'h70};
    logic [7:0] sv [11] = '{8'h0d, 8'h03, 8'h0c, 8'h0e, 8'h0f, 8'h00, 8'h01, 8'h02, 8'h0a, 8'h0b, 8'h0c};
    rdr(OFS_ATTR, 32'h64);
    for (int i = 0; i < 11; i++) begin
      nw(NA, av[i]);
      chk(attr, av[i]);
      rdr(OFS_SELECT, sv[i]);
      wr(OFS_ATTR, 32'h64);
      chk(br, RESP_OKAY);
      wr(OFS_SELECT, sv[i]);
      rdr(OFS_ATTR, (i == 10) ? 32'h02 : av[i]);
    end
    nw(NA ^ 24'h010000, 8'h03);
    nw(NA ^ 24'h000100, 8'h03);
    nw(NA ^ 24'h000001, 8'h03);
    rdr(OFS_ATTR, 32'h02);
    wr(8'h40, 32'h0);
    chk(br, RESP_SLVERR);
    rdr(8'h40, 32'h0);
  endtask
  task automatic t_coast();
    logic [7:0] sv [4] = '{8'h00, 8'h04, 8'h09, 8'h14};
    wr(OFS_IRQ_EN, 32'h2);
    foreach (sv[i]) begin
      err(sv[i], 2);
      chk({trip, cs, irq}, 3'b111);
      chk(alarm, ALARM_NET_COMM);
      rdr(OFS_ALARM, ALARM_NET_COMM);
      clr();
      wr(OFS_IRQ_CLR, 32'h7);
      chk({trip, irq}, 2'b00);
    end
    rdr(OFS_SELECT, 32'h14);
  endtask
  task automatic t_hold();
    logic [7:0] sv [5] = '{8'h03, 8'h0d, 8'h0e, 8'h0f, 8'h0e};
    wr(OFS_CTRL, 32'h2);
    foreach (sv[i]) begin
      if (i == 4) wr(OFS_CTRL, 32'h0);
      err(sv[i], 4);
      chk({trip, roff, ff, fr}, {1'b0, sv[i] == 8'h0d, i == 2, i == 3});
      le <= 0;
      repeat (2) @(posedge aclk);
    end
  endtask
  task automatic t_decel();
    wr(OFS_DECEL, 32'h1234);
    err(8'h0a, 2);
    chk({dst, trip, ramp}, {2'b10, 16'h1234});
    while (ms !== 1'b1) @(posedge aclk);
    chk(trip, 0);
    repeat (2) @(posedge aclk);
    chk(trip, 1);
    clr();
  endtask
  task automatic t_timed();
    logic [7:0] sv [3] = '{8'h01, 8'h0b, 8'h0c};
    wr(OFS_DELAY, 32'h3ff);
    rdr(OFS_DELAY, DELAY_MAX);
    wr(OFS_DELAY, 32'h2);
    // two short outages: a timer that is not cleared would sum them to a trip
    repeat (2) begin
      err(8'h02, 4);
      le <= 0;
      repeat (2) @(posedge aclk);
    end
    chk(trip, 0);
    foreach (sv[i]) begin
      err(sv[i], 3);
      chk(trip, 0);
      repeat (40) @(posedge aclk);
      chk(trip, 1);
      clr();
    end
  endtask
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    t_map();
    t_coast();
    t_hold();
    t_decel();
    t_timed();
    end_of_test();
  end
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      end_of_test();
    end
  end
endmodule
